//--- hdl/udw_host_map.vh
// Purpose: constants for the up/down wiper host controller
// Assumes: ref_clk at 250 MHz (4 ns period)
// Notes: times are kept in their printed unit, counts derived from them
//
// Summary of operation
// R1: device holds one of 32 wiper steps
// R2: device saturates at both ends, no wrap
// R3: strobe falling edge while selected moves wiper
// R4: direction high increments, low decrements
// R5: select high makes device ignore inputs
// R6: host opens session by lowering select
// R7: host sets direction before strobe falls
// R8: host repeats strobes, leaves strobe low
// R9: select rising with strobe low skips store
// R10: unstored session reverts after power cycle
// R11: strobe high, wait, raise select stores
// R12: committed store reloads at next power-up
// R13: lone select low pulse stores position
// R14: device loads stored position at power-up
// R15: device ignores pins during power-up time
// R16: working wiper position is volatile
// R17: worn memory still adjusts, stores unreliable
// R18: system may tie select high permanently
// R19: store takes up to 10 ms, pins inactive
// R20: strobe high 500 ns before select rises
// R21: strobe low 50 ns before select rises
// R22: position kept across deselect
`ifndef UDW_HOST_MAP_VH
`define UDW_HOST_MAP_VH
`define UDW_CLK_PERIOD_NS 4
`define UDW_STEPS 32
`define UDW_POS_MAX 5'h1F
`define UDW_POS_MIN 5'h00
`define UDW_SEL_SETUP_NS 50
`define UDW_DIR_SETUP_NS 100
`define UDW_STB_LOW_NS 50
`define UDW_STB_HIGH_NS 100
`define UDW_STROBE_TO_DESELECT_NS 500
`define UDW_SELECT_HIGH_NS 100
`define UDW_LOW_TO_DESELECT_NS 50
`define UDW_SELECT_PULSE_NS 100
`define UDW_STORE_MS 10
`define UDW_POWERUP_MS 2
`define UDW_NS_TO_CYC(t) (((t) + `UDW_CLK_PERIOD_NS - 1) / `UDW_CLK_PERIOD_NS)
`define UDW_POWERUP_CYC 24'h07A120
`define UDW_STORE_CYC 24'h2625A0
`endif

//--- hdl/udw_host.v
// Purpose: host controller driving select, step and direction pins
// Assumes: device powered with this block's reset; inputs synchronous
// Notes: one command at a time; busy covers power-up and store waits
`timescale 1ns/10ps
`default_nettype none
`include "udw_host_map.vh"
module udw_host #(
  parameter [23:0] POWERUP_CYC = `UDW_POWERUP_CYC,
  parameter [23:0] STORE_CYC = `UDW_STORE_CYC
) (
  input wire ref_clk,
  input wire rst_n,
  input wire cmdValid,
  output wire cmdReady,
  input wire [4:0] cmdTarget,
  input wire cmdCommit,
  input wire cmdStoreOnly,
  output reg [4:0] curPos_ff,
  output reg posKnown_ff,
  output reg selectN_ff,
  output reg strobeN_ff,
  output reg dirUp_ff,
  output wire busy
);
  // ------------------------------------------------------------
  // timing counts
  // ------------------------------------------------------------
  localparam integer SEL_I = `UDW_NS_TO_CYC(`UDW_SEL_SETUP_NS);
  localparam integer DIR_I = `UDW_NS_TO_CYC(`UDW_DIR_SETUP_NS);
  localparam integer LOW_I = `UDW_NS_TO_CYC(`UDW_STB_LOW_NS);
  localparam integer HIGH_I = `UDW_NS_TO_CYC(`UDW_STB_HIGH_NS);
  localparam integer TDS_I = `UDW_NS_TO_CYC(`UDW_STROBE_TO_DESELECT_NS);
  localparam integer CPH_I = `UDW_NS_TO_CYC(`UDW_SELECT_HIGH_NS);
  localparam integer LDS_I = `UDW_NS_TO_CYC(`UDW_LOW_TO_DESELECT_NS);
  localparam integer CLP_I = `UDW_NS_TO_CYC(`UDW_SELECT_PULSE_NS);
  // ------------------------------------------------------------
  // counts cut to the counter width
  // ------------------------------------------------------------
  localparam [23:0] SEL_CYC = SEL_I[23:0];
  localparam [23:0] DIR_CYC = DIR_I[23:0];
  localparam [23:0] LOW_CYC = LOW_I[23:0];
  localparam [23:0] HIGH_CYC = HIGH_I[23:0];
  localparam [23:0] TDS_CYC = TDS_I[23:0];
  localparam [23:0] CPH_CYC = CPH_I[23:0];
  localparam [23:0] LDS_CYC = LDS_I[23:0];
  localparam [23:0] CLP_CYC = CLP_I[23:0];
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [3:0] S_PWR = 4'h0;
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_SEL = 4'h2;
  localparam [3:0] S_HIGH = 4'h3;
  localparam [3:0] S_LOW = 4'h4;
  localparam [3:0] S_ENDC = 4'h5;
  localparam [3:0] S_ENDN = 4'h6;
  localparam [3:0] S_PULSE = 4'h7;
  localparam [3:0] S_STORE = 4'h8;
  localparam [3:0] S_GAP = 4'h9;
  reg [3:0] state_ff;
  reg [23:0] cnt_ff;
  reg [4:0] target_ff;
  reg commit_ff;
  wire cntDone = (cnt_ff == 24'h000000);
  wire atTarget = (curPos_ff == target_ff);
  assign cmdReady = (state_ff == S_IDLE);
  assign busy = (state_ff == S_PWR) || (state_ff == S_STORE);
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_PWR;
      cnt_ff <= 24'h000000;
      target_ff <= 5'h00;
      commit_ff <= 1'b0;
      curPos_ff <= 5'h00;
      posKnown_ff <= 1'b0;
      selectN_ff <= 1'b1; // R18
      strobeN_ff <= 1'b1;
      dirUp_ff <= 1'b1;
    end else begin
      if (!cntDone) begin
        cnt_ff <= cnt_ff - 24'h000001;
      end
      case (state_ff)
        S_PWR: begin
          // wait out power-up; pins held idle, posKnown_ff high until the wait ends
          if (cnt_ff == 24'h000000 && posKnown_ff == 1'b0) begin
            cnt_ff <= POWERUP_CYC; // R15 R14
            posKnown_ff <= 1'b1;
          end else if (cntDone) begin
            posKnown_ff <= 1'b0; // R16 R17
            state_ff <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (cmdValid) begin
            target_ff <= cmdTarget;
            commit_ff <= cmdCommit;
            if (!cmdStoreOnly && !cmdCommit && cmdTarget == curPos_ff) begin
              // nothing to move or store: pins stay idle
              cnt_ff <= CPH_CYC;
              state_ff <= S_GAP;
            end else if (cmdStoreOnly) begin
              selectN_ff <= 1'b0; // R13
              cnt_ff <= CLP_CYC; // R13
              state_ff <= S_PULSE;
            end else begin
              selectN_ff <= 1'b0; // R6
              cnt_ff <= SEL_CYC;
              state_ff <= S_SEL;
            end
          end
        end
        S_SEL: begin
          if (cntDone) begin
            dirUp_ff <= (target_ff > curPos_ff); // R4
            cnt_ff <= DIR_CYC; // R7
            state_ff <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (cntDone) begin
            if (atTarget) begin
              // no edge needed: strobe stays high before deselect
              cnt_ff <= TDS_CYC; // R20
              state_ff <= S_ENDC;
            end else begin
              strobeN_ff <= 1'b0; // R3
              cnt_ff <= LOW_CYC;
              state_ff <= S_LOW;
              if (dirUp_ff && curPos_ff != `UDW_POS_MAX) begin
                curPos_ff <= curPos_ff + 5'h01; // R2 R1
              end else if (!dirUp_ff && curPos_ff != `UDW_POS_MIN) begin
                curPos_ff <= curPos_ff - 5'h01; // R2
              end
            end
          end
        end
        S_LOW: begin
          if (cntDone) begin
            if (atTarget) begin // R8
              // final edge done: strobe stays low without commit, rises for commit
              if (commit_ff) begin
                strobeN_ff <= 1'b1; // R11
                cnt_ff <= TDS_CYC; // R20
                state_ff <= S_ENDC;
              end else begin
                cnt_ff <= LDS_CYC; // R21
                state_ff <= S_ENDN;
              end
            end else begin
              strobeN_ff <= 1'b1;
              dirUp_ff <= (target_ff > curPos_ff);
              cnt_ff <= HIGH_CYC;
              state_ff <= S_HIGH;
            end
          end
        end
        S_ENDC: begin
          strobeN_ff <= 1'b1;
          if (cntDone && strobeN_ff) begin
            selectN_ff <= 1'b1; // R11
            cnt_ff <= STORE_CYC; // R19 R12
            state_ff <= S_STORE;
          end else if (cntDone) begin
            cnt_ff <= TDS_CYC; // R20
          end
        end
        S_ENDN: begin
          if (cntDone) begin
            selectN_ff <= 1'b1; // R9 R10
            cnt_ff <= CPH_CYC;
            state_ff <= S_GAP;
          end
        end
        S_PULSE: begin
          if (cntDone) begin
            selectN_ff <= 1'b1; // R13
            cnt_ff <= STORE_CYC; // R19
            state_ff <= S_STORE;
          end
        end
        S_STORE: begin
          // pins idle while the device writes memory
          if (cntDone) begin
            state_ff <= S_GAP; // R19
          end
        end
        S_GAP: begin
          strobeN_ff <= 1'b1; // R22
          if (cntDone) begin
            state_ff <= S_IDLE; // R5
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- dv/udw_wiper_model.sv
// Purpose: behavioural up/down wiper device on the host pins
// Assumes: powerOn high while the device has supply
// Notes: event driven, times in ns
`timescale 1ns/10ps
`default_nettype none
module udw_wiper_model (
  input wire logic powerOn,
  input wire logic selectN,
  input wire logic strobeN,
  input wire logic dirUp,
  output logic [4:0] wiperPos,
  output logic [4:0] nvPos
);
  logic live = 1'b0;
  initial nvPos = 5'h00;
  always @(powerOn) begin
    live = 1'b0;
    wiperPos = powerOn ? nvPos : ~nvPos;
    if (powerOn) #40 live = powerOn;
  end
  always @(negedge strobeN) begin
    if (live && !selectN && dirUp)
      wiperPos = wiperPos + {4'h0, wiperPos != 5'h1F};
    else if (live && !selectN)
      wiperPos = wiperPos - {4'h0, wiperPos != 5'h00};
  end
  always @(posedge selectN) begin
    if (live && strobeN) begin
      live = 1'b0;
      nvPos = wiperPos;
      #60 live = powerOn;
    end
  end
endmodule
`default_nettype wire

//--- dv/udw_host_properties.sv
// Purpose: pin timing checks on udw_host
// Assumes: ref_clk period 4 ns
// Notes: strobe age counts cycles since the last strobe change
`timescale 1ns/10ps
`default_nettype none
module udw_host_properties #(parameter POWERUP_CYC = 20, STORE_CYC = 20) (
  input wire ref_clk,
  input wire rst_n,
  input wire cmdValid,
  input wire cmdReady,
  input wire [4:0] cmdTarget,
  input wire cmdCommit,
  input wire cmdStoreOnly,
  input wire [4:0] curPos_ff,
  input wire posKnown_ff,
  input wire selectN_ff,
  input wire strobeN_ff,
  input wire dirUp_ff,
  input wire busy
);
  logic stbLvl_ff;
  logic [7:0] stbAge_ff;
  logic stepped_ff;
  logic [7:0] selAge_ff;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stbLvl_ff <= 1'b1;
      stbAge_ff <= 8'h00;
      stepped_ff <= 1'b0;
      selAge_ff <= 8'h00;
    end else begin
      stbLvl_ff <= strobeN_ff;
      stepped_ff <= !selectN_ff && (stepped_ff || (stbLvl_ff && !strobeN_ff));
      selAge_ff <= selectN_ff ? 8'h00 :
        selAge_ff + {7'h00, selAge_ff != 8'hFF};
      stbAge_ff <= (strobeN_ff != stbLvl_ff) ? 8'h01 :
        stbAge_ff + {7'h00, stbAge_ff != 8'hFF};
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence commitEnd;
    $rose(selectN_ff) && strobeN_ff;
  endsequence
  sequence abortEnd;
    $rose(selectN_ff) && !strobeN_ff;
  endsequence
  sequence stepCommit;
    $rose(selectN_ff) && strobeN_ff && stepped_ff;
  endsequence
  sequence loneStore;
    $rose(selectN_ff) && strobeN_ff && !stepped_ff;
  endsequence
  pwr_idle_a: assert property (posKnown_ff |-> selectN_ff && strobeN_ff)
    else $error("pins moved in power-up wait");
  strobe_sel_a: assert property ($fell(strobeN_ff) |-> !selectN_ff)
    else $error("strobe outside session");
  dir_setup_a: assert property ($fell(strobeN_ff) |->
    $past(dirUp_ff, 25) == dirUp_ff) else $error("direction setup short");
  commit_gap_a: assert property (stepCommit |-> stbAge_ff >= 8'h7D)
    else $error("strobe high too short");
  pulse_width_a: assert property (loneStore |-> selAge_ff >= 8'h19)
    else $error("select store pulse too short");
  abort_gap_a: assert property (abortEnd |-> stbAge_ff >= 8'h0D)
    else $error("strobe low to deselect short");
  strobe_low_a: assert property ($rose(strobeN_ff) |-> stbAge_ff >= 8'h0D)
    else $error("strobe low too short");
  store_busy_a: assert property (commitEnd |-> ##[0:2] busy)
    else $error("no store wait");
  abort_free_a: assert property (abortEnd |-> !busy [*8])
    else $error("store wait after abort");
endmodule
bind udw_host udw_host_properties #(.POWERUP_CYC(POWERUP_CYC),
  .STORE_CYC(STORE_CYC)) udw_host_properties_i (.*);
`default_nettype wire

//--- dv/udw_testbench.sv
// Purpose: self-checking bench for udw_host with a wiper model
// Assumes: short power-up and store counts
// Notes: rst_n doubles as the device supply
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic [4:0] cmdTarget = 5'h00;
  logic cmdCommit = 1'b0;
  logic cmdStoreOnly = 1'b0;
  wire cmdReady, selectN, strobeN, dirUp, busy, posKnown;
  wire [4:0] curPos, wiperPos, nvPos;
  int miscompares = 0;
  int checked = 0;
  always #2 ref_clk = ~ref_clk;
  udw_host #(.POWERUP_CYC(24'h000014), .STORE_CYC(24'h000014)) udw_host_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdTarget(cmdTarget), .cmdCommit(cmdCommit),
    .cmdStoreOnly(cmdStoreOnly), .curPos_ff(curPos), .posKnown_ff(posKnown),
    .selectN_ff(selectN), .strobeN_ff(strobeN), .dirUp_ff(dirUp), .busy(busy));
  udw_wiper_model udw_wiper_model_i (.powerOn(rst_n), .selectN(selectN),
    .strobeN(strobeN), .dirUp(dirUp), .wiperPos(wiperPos), .nvPos(nvPos));
  task chk(input logic [4:0] seen, input logic [4:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task power_up;
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({4'h0, busy}, 5'h01);
    chk({4'h0, posKnown}, 5'h01);
    chk({4'h0, selectN & strobeN}, 5'h01);
  endtask
  task cmd(input logic [4:0] tgt, input logic com, input logic sto);
    int n;
    n = 0;
    cmdTarget <= tgt;
    cmdCommit <= com;
    cmdStoreOnly <= sto;
    cmdValid <= 1'b1;
    do @(posedge ref_clk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      miscompares++;
      stop_test;
    end
  endtask
  task t_commit_abort;
    cmd(5'h1F, 1'b1, 1'b0);
    chk(wiperPos, 5'h1F);
    chk(nvPos, 5'h1F);
    cmd(5'h05, 1'b0, 1'b0);
    chk(wiperPos, 5'h05);
    chk(curPos, 5'h05);
    chk(nvPos, 5'h1F);
  endtask
  task t_power_saturate;
    power_up;
    chk(wiperPos, 5'h1F);
    cmd(5'h02, 1'b0, 1'b0);
    chk(wiperPos, 5'h1F);
    chk(curPos, 5'h02);
    chk({3'h0, busy, posKnown}, 5'h00);
  endtask
  task t_store_only;
    cmd(5'h02, 1'b0, 1'b0);
    chk(wiperPos, 5'h1F);
    chk(nvPos, 5'h1F);
    cmd(5'h00, 1'b0, 1'b0);
    chk(wiperPos, 5'h1D);
    cmd(5'h00, 1'b0, 1'b1);
    chk(wiperPos, 5'h1D);
    chk(nvPos, 5'h1D);
    power_up;
    chk(wiperPos, 5'h1D);
    cmd(5'h03, 1'b0, 1'b0);
    chk(wiperPos, 5'h1F);
    cmd(5'h03, 1'b1, 1'b0);
    chk(wiperPos, 5'h1F);
    chk(nvPos, 5'h1F);
  endtask
  initial begin
    power_up;
    t_commit_abort;
    t_power_saturate;
    t_store_only;
    stop_test;
  end
  initial begin
    #100000;
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
